// [hdl/homing_reference_sequencer.sv]
// Homing sequencer: limit switches, cam and zero pulse referencing
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// RL1: Type 1 runs negative, reverses on negative limit, zero after its fall.
// RL2: Type 2 runs positive, reverses on positive limit, zero after its fall.
// RL3: Type 3, cam off: run positive, reverse on cam, zero after cam fall.
// RL4: Type 4, cam off: run positive, zero after cam rise.
// RL5: Type 3, cam on: run negative, zero after cam goes inactive.
// RL6: Type 4, cam on: run negative, reverse on cam fall, zero after rise.
// RL7: Type 5, cam on: run positive, zero after cam fall.
// RL8: Type 6, cam on: run positive, reverse on cam fall, zero after rise.
// RL9: Type 5, cam off: run negative, reverse on cam, zero after fall.
// RL10: Type 6, cam off: run negative, zero after cam rise.
// RL11: Type 7, cam off: run positive, reverse on cam, zero after fall.
// RL12: Type 8, cam off: run positive, zero is first pulse with cam active.
// RL13: Types 9 and 10 from cam off run positive past the cam.
// RL14: Type 7, cam on: run negative, zero after cam fall.
// RL15: Type 8, cam on: run negative, reverse on cam fall, zero after rise.
// RL16: Type 9 beyond cam: reverse once cam inactive, zero after rise.
// RL17: Type 10 beyond cam: zero after cam fall.
// RL18: Types 7 to 10 reverse when positive limit becomes active; the code turns only in ST_SEEK or ST_ARM, not in ST_ZERO.
// RL19: After that reversal, type 7 zeroes after passing the cam.
// RL20: No-referencing mode adds offset at first power stage enable.
// RL21: Position-reset mode clears position, then adds the offset.
// RL22: Position corrections are one step, never a ramp.
// RL23: On zero capture stop, load offset, flag referencing complete.
module homing_reference_sequencer #(
  parameter int POS_W = homing_pkg::POS_W_DEF
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic start,
  input wire logic [homing_pkg::TYPE_W-1:0] homing_type,
  input wire logic power_on,
  input wire logic cam,
  input wire logic limit_neg,
  input wire logic limit_pos,
  input wire logic zero_pulse,
  input wire logic [POS_W-1:0] actual_pos,
  input wire logic [POS_W-1:0] zero_offset,
  output logic move_pos,
  output logic move_neg,
  output logic busy,
  output logic ref_done,
  output logic pos_load,
  output logic [POS_W-1:0] pos_value
);
  import homing_pkg::*;

  // ----------------------------------------
  // Plan table
  // ----------------------------------------
  // Start plan per type, cam level and limit reversal
  function automatic logic [7:0] plan_of(
    input logic [5:0] t,
    input logic c,
    input logic l
  );
    plan_of = PLAN_RESET;
    case (t)
      // RL1 negative limit seek
      TYPE_01: plan_of = {DIR_NEG, 1'b0, EV_LN_RISE, EV_LN_FALL};
      // RL2 positive limit seek
      TYPE_02: plan_of = {DIR_POS, 1'b0, EV_LP_RISE, EV_LP_FALL};
      // RL3 RL5 cam level picks way
      TYPE_03: plan_of = c ? {DIR_NEG, 1'b0, EV_NONE, EV_CAM_FALL}
        : {DIR_POS, 1'b0, EV_CAM_RISE, EV_CAM_FALL};
      // RL4 RL6 cam level picks way
      TYPE_04: plan_of = c ? {DIR_NEG, 1'b0, EV_CAM_FALL, EV_CAM_RISE}
        : {DIR_POS, 1'b0, EV_NONE, EV_CAM_RISE};
      // RL7 RL9 cam level picks way
      TYPE_05: plan_of = c ? {DIR_POS, 1'b0, EV_NONE, EV_CAM_FALL}
        : {DIR_NEG, 1'b0, EV_CAM_RISE, EV_CAM_FALL};
      // RL8 RL10 cam level picks way
      TYPE_06: plan_of = c ? {DIR_POS, 1'b0, EV_CAM_FALL, EV_CAM_RISE}
        : {DIR_NEG, 1'b0, EV_NONE, EV_CAM_RISE};
      // RL11 RL14 RL19 limit turn and cam-on share a plan
      TYPE_07: plan_of = (l || c) ? {DIR_NEG, 1'b0, EV_NONE, EV_CAM_FALL}
        : {DIR_POS, 1'b0, EV_CAM_RISE, EV_CAM_FALL};
      // RL12 RL15 gated pulse or reverse
      TYPE_08: plan_of = (l || c) ? {DIR_NEG, 1'b0, EV_CAM_FALL, EV_CAM_RISE}
        : {DIR_POS, 1'b1, EV_NONE, EV_CAM_RISE};
      // RL13 RL16 pass cam, come back; cam level does not matter
      TYPE_09: plan_of = l ? {DIR_NEG, 1'b1, EV_NONE, EV_CAM_RISE}
        : {DIR_POS, 1'b0, EV_CAM_FALL, EV_CAM_RISE};
      // RL13 RL17 pass cam, next pulse
      TYPE_10: plan_of = l ? {DIR_NEG, 1'b0, EV_CAM_RISE, EV_CAM_FALL}
        : {DIR_POS, 1'b0, EV_NONE, EV_CAM_FALL};
      default: plan_of = PLAN_RESET;
    endcase
  endfunction

  // ----------------------------------------
  // Input edges
  // ----------------------------------------
  logic cam_q;
  logic lneg_q;
  logic lpos_q;
  logic pwr_q;
  logic pwr_seen;

  // Previous levels; inputs are already synchronous
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cam_q <= 1'b0;
      lneg_q <= 1'b0;
      lpos_q <= 1'b0;
      pwr_q <= 1'b0;
    end else begin
      cam_q <= cam;
      lneg_q <= limit_neg;
      lpos_q <= limit_pos;
      pwr_q <= power_on;
    end
  end

  // True when the named edge happens this cycle
  function automatic logic ev_hit(input logic [2:0] ev);
    case (ev)
      EV_CAM_RISE: ev_hit = cam && !cam_q;
      EV_CAM_FALL: ev_hit = !cam && cam_q;
      EV_LN_RISE: ev_hit = limit_neg && !lneg_q;
      EV_LN_FALL: ev_hit = !limit_neg && lneg_q;
      EV_LP_RISE: ev_hit = limit_pos && !lpos_q;
      EV_LP_FALL: ev_hit = !limit_pos && lpos_q;
      default: ev_hit = 1'b0;
    endcase
  endfunction

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  home_state_e state;
  logic [7:0] plan;
  logic [5:0] cfg_type;
  logic [7:0] start_plan;
  logic [7:0] lim_plan;
  logic [2:0] rev_ev;
  logic [2:0] arm_ev;
  logic is_homing;
  logic cam_type;
  logic accept;
  logic lp_turn;
  logic capture;

  assign start_plan = plan_of(homing_type, cam, 1'b0);
  assign lim_plan = plan_of(cfg_type, 1'b0, 1'b1);
  assign rev_ev = plan[PL_REV_LO +: 3];
  assign arm_ev = plan[PL_ARM_LO +: 3];
  assign is_homing = homing_type >= TYPE_01 && homing_type <= TYPE_10;
  assign cam_type = cfg_type >= TYPE_07 && cfg_type <= TYPE_10;
  assign accept = start && state == ST_IDLE && is_homing;
  // RL18 positive limit forces a turn in ST_SEEK or ST_ARM
  assign lp_turn = cam_type && plan[PL_DIR] && limit_pos && !lpos_q
    && (state == ST_SEEK || state == ST_ARM);
  // RL12 gate lets only cam-active pulses count
  assign capture = state == ST_ZERO && zero_pulse
    && (!plan[PL_GATE] || cam);

  // Walks seek, reverse, arm and zero steps
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_IDLE;
      plan <= PLAN_RESET;
      cfg_type <= 6'h00;
    end else begin
      case (state)
        ST_IDLE: begin
          if (accept) begin
            cfg_type <= homing_type;
            plan <= start_plan;
            if (start_plan[PL_REV_LO +: 3] == EV_NONE)
              state <= ST_ARM;
            else
              state <= ST_SEEK;
          end
        end
        ST_SEEK: begin
          if (lp_turn) begin
            // RL18 RL19 replan heading negative
            plan <= lim_plan;
            if (lim_plan[PL_REV_LO +: 3] == EV_NONE)
              state <= ST_ARM;
            else
              state <= ST_SEEK;
          end else if (ev_hit(rev_ev)) begin
            // RL1 turn round on the edge
            plan[PL_DIR] <= ~plan[PL_DIR];
            state <= ST_ARM;
          end
        end
        ST_ARM: begin
          if (lp_turn) begin
            // RL18 turn also while armed
            plan <= lim_plan;
            if (lim_plan[PL_REV_LO +: 3] == EV_NONE)
              state <= ST_ARM;
            else
              state <= ST_SEEK;
          end else if (ev_hit(arm_ev)) begin
            state <= ST_ZERO;
          end
        end
        ST_ZERO: begin
          // RL23 stop on captured pulse
          if (capture)
            state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Motion follows state; idle means stopped
  assign busy = state != ST_IDLE;
  assign move_pos = busy && plan[PL_DIR];
  assign move_neg = busy && !plan[PL_DIR];

  // ----------------------------------------
  // Position load and status
  // ----------------------------------------
  logic nref_evt;
  logic preset_evt;

  // RL20 first power stage enable only
  assign nref_evt = power_on && !pwr_q && !pwr_seen
    && homing_type == TYPE_NO_REF;
  assign preset_evt = start && state == ST_IDLE
    && homing_type == TYPE_POS_RESET;

  // Power enable seen once; later enables do nothing
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn)
      pwr_seen <= 1'b0;
    else if (power_on && !pwr_q)
      pwr_seen <= 1'b1;
  end

  // RL22 one-cycle step load, no ramp
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pos_load <= 1'b0;
      pos_value <= '0;
    end else begin
      pos_load <= capture || nref_evt || preset_evt;
      if (capture)
        // RL23 offset becomes position
        pos_value <= zero_offset;
      else if (nref_evt)
        // RL20 offset added to position
        pos_value <= actual_pos + zero_offset;
      else if (preset_evt)
        // RL21 zero then add offset
        pos_value <= zero_offset;
    end
  end

  // Complete flag held until a new homing run
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn)
      ref_done <= 1'b0;
    else if (capture || nref_evt || preset_evt)
      ref_done <= 1'b1;
    else if (accept)
      ref_done <= 1'b0;
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  property p_t1_start;
    accept && homing_type == TYPE_01 |=> move_neg && state == ST_SEEK;
  endproperty
  a_t1_start: assert property (p_t1_start) // RL1
    else $error("type 1 not heading negative");

  sequence s_t1_turn;
    state == ST_SEEK && cfg_type == TYPE_01 && limit_neg && !lneg_q;
  endsequence
  property p_t1_turn;
    s_t1_turn |=> move_pos && state == ST_ARM;
  endproperty
  a_t1_turn: assert property (p_t1_turn) // RL1
    else $error("type 1 did not reverse on limit");

  property p_t2_start;
    accept && homing_type == TYPE_02 |=> move_pos;
  endproperty
  a_t2_start: assert property (p_t2_start) // RL2
    else $error("type 2 not heading positive");

  property p_t3_off;
    accept && homing_type == TYPE_03 && !cam |=> move_pos;
  endproperty
  a_t3_off: assert property (p_t3_off) // RL3
    else $error("type 3 cam off not positive");

  property p_t3_on;
    accept && homing_type == TYPE_03 && cam |=> move_neg && state == ST_ARM;
  endproperty
  a_t3_on: assert property (p_t3_on) // RL5
    else $error("type 3 cam on not negative");

  property p_t5_on;
    accept && homing_type == TYPE_05 && cam |=> move_pos;
  endproperty
  a_t5_on: assert property (p_t5_on) // RL7
    else $error("type 5 cam on not positive");

  property p_t6_off;
    accept && homing_type == TYPE_06 && !cam |=> move_neg;
  endproperty
  a_t6_off: assert property (p_t6_off) // RL10
    else $error("type 6 cam off not negative");

  property p_lim_turn;
    lp_turn |=> move_neg;
  endproperty
  a_lim_turn: assert property (p_lim_turn) // RL18
    else $error("no reversal at positive limit");

  sequence s_capture;
    capture ##1 pos_load;
  endsequence
  property p_capture;
    capture |=> !busy && ref_done && pos_load
      && pos_value == $past(zero_offset);
  endproperty
  a_capture: assert property (p_capture) // RL23
    else $error("capture did not stop and load offset");

  property p_step;
    s_capture |=> !pos_load;
  endproperty
  a_step: assert property (p_step) // RL22
    else $error("position load longer than one cycle");

  property p_no_ref;
    nref_evt |=> pos_load && ref_done
      && pos_value == $past(actual_pos) + $past(zero_offset);
  endproperty
  a_no_ref: assert property (p_no_ref) // RL20
    else $error("no-referencing load wrong");

  property p_preset;
    preset_evt |=> pos_load && pos_value == $past(zero_offset) && !busy;
  endproperty
  a_preset: assert property (p_preset) // RL21
    else $error("position reset load wrong");
endmodule
`default_nettype wire

// [shared/homing_pkg.sv]
// Constants and types for the homing reference sequencer
package homing_pkg;
  // Widths
  localparam int POS_W_DEF = 32;
  localparam int TYPE_W = 6;
  // Homing type codes (two's complement)
  localparam logic [5:0] TYPE_01 = 6'h01;
  localparam logic [5:0] TYPE_02 = 6'h02;
  localparam logic [5:0] TYPE_03 = 6'h03;
  localparam logic [5:0] TYPE_04 = 6'h04;
  localparam logic [5:0] TYPE_05 = 6'h05;
  localparam logic [5:0] TYPE_06 = 6'h06;
  localparam logic [5:0] TYPE_07 = 6'h07;
  localparam logic [5:0] TYPE_08 = 6'h08;
  localparam logic [5:0] TYPE_09 = 6'h09;
  localparam logic [5:0] TYPE_10 = 6'h0a;
  localparam logic [5:0] TYPE_NO_REF = 6'h3c;
  localparam logic [5:0] TYPE_POS_RESET = 6'h3b;
  // Edge events steering the plan
  localparam logic [2:0] EV_NONE = 3'h0;
  localparam logic [2:0] EV_CAM_RISE = 3'h1;
  localparam logic [2:0] EV_CAM_FALL = 3'h2;
  localparam logic [2:0] EV_LN_RISE = 3'h3;
  localparam logic [2:0] EV_LN_FALL = 3'h4;
  localparam logic [2:0] EV_LP_RISE = 3'h5;
  localparam logic [2:0] EV_LP_FALL = 3'h6;
  // Plan word layout: {dir, gate, rev[2:0], arm[2:0]}
  localparam int PL_DIR = 7;
  localparam int PL_GATE = 6;
  localparam int PL_REV_LO = 3;
  localparam int PL_ARM_LO = 0;
  localparam logic DIR_POS = 1'b1;
  localparam logic DIR_NEG = 1'b0;
  localparam logic [7:0] PLAN_RESET = 8'h00;
  // Sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SEEK = 2'b01,
    ST_ARM = 2'b10,
    ST_ZERO = 2'b11
  } home_state_e;
endpackage

// [sim/axis_model.sv]
// Behavioural axis: limit switches, reference cam and encoder zero pulse
`timescale 1ns/10ps
`default_nettype none
module axis_model #(
  parameter int LIM_NEG = 0,
  parameter int LIM_POS = 400,
  parameter int CAM_LO = 150,
  parameter int CAM_HI = 250,
  parameter int PITCH = 40,
  parameter int MARK = 20
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic move_pos,
  input wire logic move_neg,
  input wire logic set_en,
  input wire logic [31:0] set_pos,
  input wire logic [3:0] step_div,
  output logic cam,
  output logic limit_neg,
  output logic limit_pos,
  output logic zero_pulse,
  output logic [31:0] axis_pos,
  output logic [31:0] zero_at
);
  int pos;
  int tick;
  logic stepped;
  // ----------------------------------------
  // Travel
  // ----------------------------------------
  // One step per step_div cycles; a slow axis overshoots less per edge
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pos <= 100;
      tick <= 0;
      stepped <= 1'b0;
    end else if (set_en) begin
      pos <= int'(set_pos);
      tick <= 0;
      stepped <= 1'b0;
    end else begin
      stepped <= 1'b0;
      if (move_pos ^ move_neg) begin
        if (tick + 1 >= int'(step_div)) begin
          tick <= 0;
          pos <= move_pos ? pos + 1 : pos - 1;
          stepped <= 1'b1;
        end else begin
          tick <= tick + 1;
        end
      end
    end
  end
  // Switches follow position; marks sit away from cam edges on purpose
  assign cam = (pos >= CAM_LO) && (pos <= CAM_HI);
  assign limit_neg = pos <= LIM_NEG;
  assign limit_pos = pos >= LIM_POS;
  assign zero_pulse = stepped && (pos % PITCH == MARK);
  assign axis_pos = 32'(pos);
  // Where the last pulse fired, so a capture can be judged by place
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      zero_at <= 32'h0;
    end else if (zero_pulse) begin
      zero_at <= axis_pos;
    end
  end
endmodule
`default_nettype wire

// [sim/homing_reference_sequencer_bench.sv]
// Self-checking bench for the homing reference sequencer
`timescale 1ns/10ps
`default_nettype none
module homing_reference_sequencer_bench;
  import homing_pkg::*;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic start = 1'b0;
  logic [5:0] homing_type = 6'h00;
  logic power_on = 1'b0;
  logic [31:0] zero_offset = 32'h0000_1234;
  logic set_en = 1'b0;
  logic [31:0] set_pos = 32'h0;
  logic [3:0] step_div = 4'h1;
  logic cam, limit_neg, limit_pos, zero_pulse, move_pos, move_neg, busy, ref_done, pos_load;
  logic [31:0] axis_pos, zero_at, pos_value;
  int n_fail = 0;
  int samples_checked = 0;
  homing_reference_sequencer i_homing_reference_sequencer (.core_clk(core_clk),
    .resetn(resetn), .start(start), .homing_type(homing_type), .power_on(power_on),
    .cam(cam), .limit_neg(limit_neg), .limit_pos(limit_pos), .zero_pulse(zero_pulse),
    .actual_pos(axis_pos), .zero_offset(zero_offset), .move_pos(move_pos),
    .move_neg(move_neg), .busy(busy), .ref_done(ref_done), .pos_load(pos_load),
    .pos_value(pos_value));
  axis_model i_axis_model (.core_clk(core_clk), .resetn(resetn), .move_pos(move_pos),
    .move_neg(move_neg), .set_en(set_en), .set_pos(set_pos), .step_div(step_div),
    .cam(cam), .limit_neg(limit_neg), .limit_pos(limit_pos), .zero_pulse(zero_pulse),
    .axis_pos(axis_pos), .zero_at(zero_at));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  initial begin
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("Checks made %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Bounded wait for the load pulse, then see that it lasts one cycle
  task automatic wait_load(input int lim);
    int n;
    n = 0;
    while (pos_load !== 1'b1 && n < lim) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    check("pos_load", pos_load, 1'b1);
    check("ref_done", ref_done, 1'b1);
    @(posedge core_clk);
    #1;
    check("pos_load drop", pos_load, 1'b0);
  endtask
  // Park the axis, start one run, judge direction, capture place and end state
  task automatic run_home(input logic [5:0] t, input int p, input logic dir, input int zexp,
                          input bit poke);
    @(posedge core_clk);
    set_en <= 1'b1;
    set_pos <= 32'(p);
    @(posedge core_clk);
    set_en <= 1'b0;
    start <= 1'b1;
    homing_type <= t;
    @(posedge core_clk);
    start <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    check("busy", busy, 1'b1);
    check("ref_done cleared", ref_done, 1'b0);
    check("move_pos", move_pos, dir);
    check("move_neg", move_neg, !dir);
    if (poke) begin
      // A second start while busy must change nothing
      @(posedge core_clk);
      start <= 1'b1;
      homing_type <= TYPE_POS_RESET;
      @(posedge core_clk);
      start <= 1'b0;
      // Look in the very cycle a wrongly taken reset would pulse
      #1;
      check("refused load", pos_load, 1'b0);
      check("refused done", ref_done, 1'b0);
      repeat (2) @(posedge core_clk);
      #1;
      check("refused dir", move_pos, dir);
    end
    wait_load(4000);
    check("zero place", zero_at, 32'(zexp));
    check("pos_value", pos_value, zero_offset);
    check("stopped", {busy, move_pos, move_neg}, 32'h0);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_no_ref();
    @(posedge core_clk);
    homing_type <= TYPE_NO_REF;
    power_on <= 1'b1;
    @(posedge core_clk);
    #1;
    wait_load(4);
    check("offset added", pos_value, 32'd100 + zero_offset);
    @(posedge core_clk);
    power_on <= 1'b0;
    repeat (2) @(posedge core_clk);
    power_on <= 1'b1;
    // A wrong load would stand only in the cycle after the rise
    @(posedge core_clk);
    #1;
    check("second power rise", pos_load, 1'b0);
  endtask
  task automatic t_pos_reset();
    @(posedge core_clk);
    zero_offset <= 32'h0000_0abc;
    start <= 1'b1;
    homing_type <= TYPE_POS_RESET;
    @(posedge core_clk);
    start <= 1'b0;
    #1;
    wait_load(4);
    check("reset value", pos_value, 32'h0000_0abc);
  endtask
  task automatic t_undefined();
    @(posedge core_clk);
    start <= 1'b1;
    homing_type <= 6'h0b;
    @(posedge core_clk);
    start <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
    check("undefined ignored", {busy, move_pos, move_neg, pos_load}, 32'h0);
  endtask
  task automatic t_limit_types();
    run_home(TYPE_01, 100, DIR_NEG, 20, 1'b0);
    run_home(TYPE_02, 300, DIR_POS, 380, 1'b0);
  endtask
  task automatic t_cam_3_to_6();
    step_div <= 4'h2;
    run_home(TYPE_03, 100, DIR_POS, 140, 1'b0);
    run_home(TYPE_04, 100, DIR_POS, 180, 1'b1);
    run_home(TYPE_03, 200, DIR_NEG, 140, 1'b0);
    run_home(TYPE_04, 200, DIR_NEG, 180, 1'b0);
    run_home(TYPE_05, 200, DIR_POS, 260, 1'b0);
    run_home(TYPE_06, 200, DIR_POS, 220, 1'b0);
    run_home(TYPE_05, 300, DIR_NEG, 260, 1'b0);
    run_home(TYPE_06, 300, DIR_NEG, 220, 1'b0);
    step_div <= 4'h1;
  endtask
  task automatic t_cam_7_to_10();
    run_home(TYPE_07, 100, DIR_POS, 140, 1'b0);
    run_home(TYPE_08, 100, DIR_POS, 180, 1'b0);
    run_home(TYPE_09, 100, DIR_POS, 220, 1'b0);
    run_home(TYPE_10, 100, DIR_POS, 260, 1'b0);
    run_home(TYPE_07, 200, DIR_NEG, 140, 1'b0);
    run_home(TYPE_08, 200, DIR_NEG, 180, 1'b0);
    run_home(TYPE_09, 200, DIR_POS, 220, 1'b0);
    run_home(TYPE_10, 200, DIR_POS, 260, 1'b0);
  endtask
  task automatic t_limit_reversal();
    run_home(TYPE_07, 300, DIR_POS, 140, 1'b0);
    run_home(TYPE_08, 300, DIR_POS, 180, 1'b0);
    run_home(TYPE_09, 300, DIR_POS, 220, 1'b0);
    run_home(TYPE_10, 300, DIR_POS, 260, 1'b0);
  endtask
  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge core_clk);
    resetn <= 1'b1;
    t_no_ref();
    t_pos_reset();
    t_undefined();
    t_limit_types();
    t_cam_3_to_6();
    t_cam_7_to_10();
    t_limit_reversal();
    final_report();
  end
  // Runs need about 4k cycles; far beyond that means a hang
  initial begin
    repeat (90000) @(posedge core_clk);
    n_fail++;
    final_report();
  end
endmodule
`default_nettype wire
